// *** design/pci_bus_pkg.sv ***
// Shared constants, state types and decode helpers for the host bus interface.
package pci_bus_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus commands driven or decoded on the command/byte-enable lines.
  localparam logic [3:0]  CMD_MEM_READ    = 4'h6;        // Memory read command.
  localparam logic [3:0]  CMD_MEM_WRITE   = 4'h7;        // Memory write command.

  ////////////////////////////////////////////////////////////////////////////
  // Target address window; the base value is a plain default.
  localparam logic [31:0] TGT_BASE        = 32'h1000_0000; // Window base address.
  localparam logic [31:0] TGT_MASK        = 32'hFFFF_F000; // Window size of 4 KiB.
  localparam logic [31:0] ADDR_STEP       = 32'h0000_0004; // One dword per data phase.

  ////////////////////////////////////////////////////////////////////////////
  // Timing figures, counted in bus clocks.
  localparam int          RESET_MIN_CLOCKS = 10;         // Least reset length the system gives.
  localparam logic [2:0]  DEVSEL_TIMEOUT  = 3'h5;        // Clocks a master waits for a target.
  localparam logic [2:0]  DEVSEL_LAST     = DEVSEL_TIMEOUT - 3'h1; // Last count before abort.

  ////////////////////////////////////////////////////////////////////////////
  // Values taken under reset.
  localparam logic [31:0] AD_RESET        = 32'h0000_0000; // Address/data register.
  localparam logic [3:0]  CBE_RESET       = 4'hF;        // Command/byte enables, none enabled.
  localparam logic        PIN_N_RESET     = 1'b1;        // Active-low pins read deasserted.
  localparam logic [2:0]  CNT_RESET       = 3'h0;        // Watchdog counter.

  ////////////////////////////////////////////////////////////////////////////
  // State machines of the target and master halves.
  typedef enum logic [2:0] {T_IDLE, T_DECODE, T_DATA, T_WAIT, T_TURN} tgt_state_t;
  typedef enum logic [2:0] {M_IDLE, M_REQ, M_ADDR, M_DATA, M_DONE} mst_state_t;

  // True when an address phase falls in the target window with a supported command.
  function automatic logic tgt_hit(input logic [31:0] addr, input logic [3:0] cmd);
    return ((addr & TGT_MASK) == TGT_BASE) &&
           ((cmd == CMD_MEM_READ) || (cmd == CMD_MEM_WRITE));
  endfunction

endpackage

// *** design/par_gen.sv ***
// Even parity generator that follows the driven address/data one clock later.
`timescale 1ns/10ps

module par_gen (
  input  wire logic        clk_sys,   // Bus clock.
  input  wire logic        resetn,    // Async reset, low.
  input  wire logic [31:0] ad_src,    // AD this clock.
  input  wire logic [3:0]  cbe_src,   // Bus C/BE this clock.
  input  wire logic        drive_en,  // AD driven.
  output logic             par_q,     // Parity of last clock.
  output logic             par_en_q   // Delayed enable.
);

  // XOR of all covered bits makes the total count of ones even.
  wire par_d = ^{ad_src, cbe_src};

  ////////////////////////////////////////////////////////////////////////////
  // Parity and its enable are both delayed one clock, so the pin keeps the
  // phase timing of the lines it covers but lags them by exactly a clock.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      par_q    <= 1'b0;
      par_en_q <= 1'b0;
    end else begin
      par_q    <= par_d;
      par_en_q <= drive_en;
    end
  end

endmodule

// *** design/devsel_watchdog.sv ***
// Watchdog that flags a master access no target has claimed in time.
`timescale 1ns/10ps

module devsel_watchdog (
  input  wire logic clk_sys,      // Bus clock.
  input  wire logic resetn,       // Async reset, low.
  input  wire logic start,        // Access begins.
  input  wire logic devsel_seen,  // Claim seen.
  input  wire logic clear,        // Access ended.
  output logic      expired_q     // No claim in time.
);

  logic [2:0] cnt_q;    // Clocks counted since the address phase.
  logic       armed_q;  // Counting is active.

  ////////////////////////////////////////////////////////////////////////////
  // A claim at any count disarms the watchdog; otherwise it fires at the limit.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_q     <= pci_bus_pkg::CNT_RESET;
      armed_q   <= 1'b0;
      expired_q <= 1'b0;
    end else if (start) begin
      cnt_q     <= pci_bus_pkg::CNT_RESET;
      armed_q   <= 1'b1;
      expired_q <= 1'b0;
    end else if (clear) begin
      armed_q   <= 1'b0;
      expired_q <= 1'b0;
    end else if (armed_q) begin
      if (devsel_seen) begin
        armed_q <= 1'b0;
      end else if (cnt_q == pci_bus_pkg::DEVSEL_LAST) begin
        armed_q   <= 1'b0;
        expired_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + 3'h1;
      end
    end
  end

endmodule

// *** design/pci_bus_interface.sv ***
// Host bus interface: target and single-phase master on the multiplexed bus.
`timescale 1ns/10ps

module pci_bus_interface (
  input  wire logic        clk_sys,                // Bus clock.
  input  wire logic        resetn,                 // Async reset, low.
  input  wire logic [31:0] ad_sample,              // Bus AD level.
  output logic      [31:0] ad_drive,               // AD drive value.
  output logic             ad_drive_en,            // AD enable.
  input  wire logic [3:0]  cmd_byte_enable_n,      // Bus C/BE level.
  output logic      [3:0]  cmd_byte_enable_n_drv,  // C/BE drive value.
  output logic             cmd_byte_enable_en,     // C/BE enable.
  output logic             par_drive,              // Parity value.
  output logic             par_drive_en,           // Parity enable.
  input  wire logic        cycle_frame_n,          // Bus frame.
  output logic             cycle_frame_n_drv,      // Frame drive.
  output logic             cycle_frame_en,         // Frame enable.
  input  wire logic        initiator_ready_n,      // Bus initiator ready.
  output logic             initiator_ready_n_drv,  // Its drive.
  output logic             initiator_ready_en,     // Its enable.
  input  wire logic        target_ready_n,         // Bus target ready.
  output logic             target_ready_n_drv,     // Its drive.
  output logic             target_ready_en,        // Its enable.
  input  wire logic        device_select_n,        // Bus device select.
  output logic             device_select_n_drv,    // Its drive.
  output logic             device_select_en,       // Its enable.
  input  wire logic        stop_n,                 // Bus stop.
  output logic             bus_request_n,          // Request out.
  output logic             bus_request_en,         // Request enable.
  input  wire logic        bus_grant_n,            // Grant in.
  output logic      [31:0] tgt_addr,               // Target address.
  input  wire logic [31:0] tgt_rdata,              // Target read data.
  output logic      [31:0] tgt_wdata,              // Target write data.
  output logic      [3:0]  tgt_be,                 // Write enables, high.
  output logic             tgt_wr,                 // Write strobe.
  input  wire logic        mst_start,              // Start access.
  input  wire logic [31:0] mst_addr,               // Access address.
  input  wire logic [3:0]  mst_cmd,                // Bus command.
  input  wire logic [3:0]  mst_be_n,               // Byte enables, low.
  input  wire logic [31:0] mst_wdata,              // Write data.
  output logic      [31:0] mst_rdata,              // Read data.
  output logic             mst_done,               // Done pulse.
  output logic             mst_abort,              // Abort pulse.
  output logic             mst_busy                // Busy level.
);

  ////////////////////////////////////////////////////////////////////////////
  // State and pin registers.
  pci_bus_pkg::tgt_state_t t_state_q, t_state_d;  // Target state.
  pci_bus_pkg::mst_state_t m_state_q, m_state_d;  // Master state.
  logic [31:0] ad_q, ad_d;            // AD drive.
  logic        ad_en_q, ad_en_d;      // AD enable.
  logic [3:0]  cbe_q, cbe_d;          // C/BE drive.
  logic        cbe_en_q, cbe_en_d;    // C/BE enable.
  logic        frame_q, frame_d;      // Frame drive.
  logic        frame_en_q, frame_en_d;   // Frame enable.
  logic        irdy_q, irdy_d;        // Ready drive.
  logic        irdy_en_q, irdy_en_d;  // Ready enable.
  logic        trdy_q, trdy_d;        // Ready drive.
  logic        trdy_en_q, trdy_en_d;  // Ready enable.
  logic        dsel_q, dsel_d;        // Select drive.
  logic        dsel_en_q, dsel_en_d;  // Select enable.
  logic        req_q, req_d;          // Request drive.
  logic        req_en_q;              // Request enable.
  logic        frame_prev_q;          // Frame last clock.
  logic [31:0] t_addr_q, t_addr_d;    // Target address.
  logic        t_write_q, t_write_d;  // Target write.
  logic [31:0] t_wdata_q, t_wdata_d;  // Write data.
  logic [3:0]  t_be_q, t_be_d;        // Write enables.
  logic        t_wr_q, t_wr_d;        // Write strobe.
  logic [31:0] m_addr_q, m_addr_d;    // Master address.
  logic [3:0]  m_cmd_q, m_cmd_d;      // Master command.
  logic [3:0]  m_be_q, m_be_d;        // Master enables.
  logic [31:0] m_wdata_q, m_wdata_d;  // Master data.
  logic [31:0] m_rdata_q, m_rdata_d;  // Read data.
  logic        m_done_q, m_done_d;    // Done pulse.
  logic        m_abort_q, m_abort_d;  // Abort pulse.
  logic        m_busy_q, m_busy_d;    // Busy level.
  logic        par_q;                 // Parity.
  logic        par_en_q;              // Parity enable.
  logic        wd_expired_q;          // Unclaimed access.

  ////////////////////////////////////////////////////////////////////////////
  // Decode of what the bus is doing this clock.
  wire addr_phase = !cycle_frame_n && frame_prev_q;
  wire xfer       = !initiator_ready_n && !target_ready_n;
  wire m_owns     = (m_state_q == pci_bus_pkg::M_ADDR) ||
                    (m_state_q == pci_bus_pkg::M_DATA) ||
                    (m_state_q == pci_bus_pkg::M_DONE);
  // Our own master cycles are never claimed by our own target.
  wire t_hit      = pci_bus_pkg::tgt_hit(ad_sample, cmd_byte_enable_n) && !m_owns;
  wire bus_idle   = cycle_frame_n && initiator_ready_n;
  wire m_write    = m_cmd_q[0];
  wire wd_start   = (m_state_q == pci_bus_pkg::M_ADDR);
  wire wd_clear   = (m_state_q == pci_bus_pkg::M_DONE);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for both halves. They never own the shared lines in the
  // same clock: the master waits for an idle target and an idle bus.
  always_comb begin
    t_state_d  = t_state_q;
    m_state_d  = m_state_q;
    ad_d       = ad_q;
    ad_en_d    = ad_en_q;
    cbe_d      = cbe_q;
    cbe_en_d   = cbe_en_q;
    frame_d    = frame_q;
    frame_en_d = frame_en_q;
    irdy_d     = irdy_q;
    irdy_en_d  = irdy_en_q;
    trdy_d     = trdy_q;
    trdy_en_d  = trdy_en_q;
    dsel_d     = dsel_q;
    dsel_en_d  = dsel_en_q;
    req_d      = req_q;
    t_addr_d   = t_addr_q;
    t_write_d  = t_write_q;
    t_wdata_d  = t_wdata_q;
    t_be_d     = t_be_q;
    t_wr_d     = 1'b0;
    m_addr_d   = m_addr_q;
    m_cmd_d    = m_cmd_q;
    m_be_d     = m_be_q;
    m_wdata_d  = m_wdata_q;
    m_rdata_d  = m_rdata_q;
    m_done_d   = 1'b0;
    m_abort_d  = 1'b0;
    m_busy_d   = m_busy_q;
    // Target half.
    case (t_state_q)
      pci_bus_pkg::T_IDLE: begin
        // Address is latched in the first clock of the frame.
        if (addr_phase && t_hit) begin
          t_addr_d  = ad_sample;
          t_write_d = (cmd_byte_enable_n == pci_bus_pkg::CMD_MEM_WRITE);
          t_state_d = pci_bus_pkg::T_DECODE;
        end
      end
      pci_bus_pkg::T_DECODE: begin
        // Claim in the second clock after the address; a read also takes the
        // lines after the turnaround clock.
        dsel_d     = 1'b0;
        dsel_en_d  = 1'b1;
        trdy_d     = 1'b0;
        trdy_en_d  = 1'b1;
        ad_d       = tgt_rdata;
        ad_en_d    = !t_write_q;
        cbe_d      = pci_bus_pkg::CBE_RESET;
        t_state_d  = pci_bus_pkg::T_DATA;
      end
      pci_bus_pkg::T_DATA: begin
        if (xfer) begin
          // A word moves only here, with both ready lines low.
          t_wr_d    = t_write_q;
          t_wdata_d = ad_sample;
          t_be_d    = ~cmd_byte_enable_n;
          t_addr_d  = t_addr_q + pci_bus_pkg::ADDR_STEP;
          trdy_d    = 1'b1;
          if (cycle_frame_n) begin
            // Frame already high: that was the final data phase.
            dsel_d    = 1'b1;
            ad_en_d   = 1'b0;
            t_state_d = pci_bus_pkg::T_TURN;
          end else begin
            t_state_d = pci_bus_pkg::T_WAIT;
          end
        end else if (bus_idle) begin
          // The initiator left without data; drop the claim.
          trdy_d    = 1'b1;
          dsel_d    = 1'b1;
          ad_en_d   = 1'b0;
          t_state_d = pci_bus_pkg::T_TURN;
        end
      end
      pci_bus_pkg::T_WAIT: begin
        // One wait state before each later burst word lets the read data follow the address.
        ad_d      = tgt_rdata;
        trdy_d    = 1'b0;
        t_state_d = pci_bus_pkg::T_DATA;
      end
      pci_bus_pkg::T_TURN: begin
        // Lines were driven high one clock; now release them.
        trdy_en_d = 1'b0;
        dsel_en_d = 1'b0;
        t_state_d = pci_bus_pkg::T_IDLE;
      end
      default: t_state_d = pci_bus_pkg::T_IDLE;
    endcase
    // Master half.
    case (m_state_q)
      pci_bus_pkg::M_IDLE: begin
        if (mst_start) begin
          m_addr_d  = mst_addr;
          m_cmd_d   = mst_cmd;
          m_be_d    = mst_be_n;
          m_wdata_d = mst_wdata;
          m_busy_d  = 1'b1;
          req_d     = 1'b0;
          m_state_d = pci_bus_pkg::M_REQ;
        end
      end
      pci_bus_pkg::M_REQ: begin
        if (!bus_grant_n && bus_idle && (t_state_q == pci_bus_pkg::T_IDLE)) begin
          frame_d    = 1'b0;
          frame_en_d = 1'b1;
          ad_d       = m_addr_q;
          ad_en_d    = 1'b1;
          cbe_d      = m_cmd_q;
          cbe_en_d   = 1'b1;
          irdy_d     = 1'b1;
          irdy_en_d  = 1'b1;
          m_state_d  = pci_bus_pkg::M_ADDR;
        end
      end
      pci_bus_pkg::M_ADDR: begin
        // Single data phase: frame rises together with initiator ready.
        frame_d   = 1'b1;
        irdy_d    = 1'b0;
        cbe_d     = m_be_q;
        ad_d      = m_wdata_q;
        ad_en_d   = m_write;
        req_d     = 1'b1;
        m_state_d = pci_bus_pkg::M_DATA;
      end
      pci_bus_pkg::M_DATA: begin
        if (xfer && !device_select_n) begin
          m_rdata_d  = ad_sample;
          m_done_d   = 1'b1;
          irdy_d     = 1'b1;
          frame_en_d = 1'b0;
          ad_en_d    = 1'b0;
          m_state_d  = pci_bus_pkg::M_DONE;
        end else if ((!stop_n && !device_select_n) || wd_expired_q) begin
          // Retry, disconnect without data, or nobody claimed: give up.
          m_abort_d  = 1'b1;
          irdy_d     = 1'b1;
          frame_en_d = 1'b0;
          ad_en_d    = 1'b0;
          m_state_d  = pci_bus_pkg::M_DONE;
        end
      end
      pci_bus_pkg::M_DONE: begin
        irdy_en_d = 1'b0;
        cbe_en_d  = 1'b0;
        m_busy_d  = 1'b0;
        m_state_d = pci_bus_pkg::M_IDLE;
      end
      default: m_state_d = pci_bus_pkg::M_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin registers. Reset leaves every enable low, so all bus outputs float,
  // including the request, and the grant cannot be seen while reset holds.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ad_q       <= pci_bus_pkg::AD_RESET;
      ad_en_q    <= 1'b0;
      cbe_q      <= pci_bus_pkg::CBE_RESET;
      cbe_en_q   <= 1'b0;
      frame_q    <= pci_bus_pkg::PIN_N_RESET;
      frame_en_q <= 1'b0;
      irdy_q     <= pci_bus_pkg::PIN_N_RESET;
      irdy_en_q  <= 1'b0;
      trdy_q     <= pci_bus_pkg::PIN_N_RESET;
      trdy_en_q  <= 1'b0;
      dsel_q     <= pci_bus_pkg::PIN_N_RESET;
      dsel_en_q  <= 1'b0;
      req_q      <= pci_bus_pkg::PIN_N_RESET;
      req_en_q   <= 1'b0;
      frame_prev_q <= pci_bus_pkg::PIN_N_RESET;
    end else begin
      ad_q       <= ad_d;
      ad_en_q    <= ad_en_d;
      cbe_q      <= cbe_d;
      cbe_en_q   <= cbe_en_d;
      frame_q    <= frame_d;
      frame_en_q <= frame_en_d;
      irdy_q     <= irdy_d;
      irdy_en_q  <= irdy_en_d;
      trdy_q     <= trdy_d;
      trdy_en_q  <= trdy_en_d;
      dsel_q     <= dsel_d;
      dsel_en_q  <= dsel_en_d;
      req_q      <= req_d;
      req_en_q   <= 1'b1;
      frame_prev_q <= cycle_frame_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and user-side registers, all back to initial values in reset.
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      t_state_q <= pci_bus_pkg::T_IDLE;
      m_state_q <= pci_bus_pkg::M_IDLE;
      t_addr_q  <= pci_bus_pkg::AD_RESET;
      t_write_q <= 1'b0;
      t_wdata_q <= pci_bus_pkg::AD_RESET;
      t_be_q    <= 4'h0;
      t_wr_q    <= 1'b0;
      m_addr_q  <= pci_bus_pkg::AD_RESET;
      m_cmd_q   <= pci_bus_pkg::CMD_MEM_READ;
      m_be_q    <= pci_bus_pkg::CBE_RESET;
      m_wdata_q <= pci_bus_pkg::AD_RESET;
      m_rdata_q <= pci_bus_pkg::AD_RESET;
      m_done_q  <= 1'b0;
      m_abort_q <= 1'b0;
      m_busy_q  <= 1'b0;
    end else begin
      t_state_q <= t_state_d;
      m_state_q <= m_state_d;
      t_addr_q  <= t_addr_d;
      t_write_q <= t_write_d;
      t_wdata_q <= t_wdata_d;
      t_be_q    <= t_be_d;
      t_wr_q    <= t_wr_d;
      m_addr_q  <= m_addr_d;
      m_cmd_q   <= m_cmd_d;
      m_be_q    <= m_be_d;
      m_wdata_q <= m_wdata_d;
      m_rdata_q <= m_rdata_d;
      m_done_q  <= m_done_d;
      m_abort_q <= m_abort_d;
      m_busy_q  <= m_busy_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parity covers our AD drive and the C/BE lines as the bus carries them,
  // since a target read shares the clock with the master's byte enables.
  par_gen u_par (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .ad_src   (ad_q),
    .cbe_src  (cmd_byte_enable_n),
    .drive_en (ad_en_q),
    .par_q    (par_q),
    .par_en_q (par_en_q)
  );

  // Watches our own accesses for a target claim.
  devsel_watchdog u_wd (
    .clk_sys     (clk_sys),
    .resetn      (resetn),
    .start       (wd_start),
    .devsel_seen (!device_select_n),
    .clear       (wd_clear),
    .expired_q   (wd_expired_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a register.
  assign ad_drive              = ad_q;
  assign ad_drive_en           = ad_en_q;
  assign cmd_byte_enable_n_drv = cbe_q;
  assign cmd_byte_enable_en    = cbe_en_q;
  assign par_drive             = par_q;
  assign par_drive_en          = par_en_q;
  assign cycle_frame_n_drv     = frame_q;
  assign cycle_frame_en        = frame_en_q;
  assign initiator_ready_n_drv = irdy_q;
  assign initiator_ready_en    = irdy_en_q;
  assign target_ready_n_drv    = trdy_q;
  assign target_ready_en       = trdy_en_q;
  assign device_select_n_drv   = dsel_q;
  assign device_select_en      = dsel_en_q;
  assign bus_request_n         = req_q;
  assign bus_request_en        = req_en_q;
  assign tgt_addr              = t_addr_q;
  assign tgt_wdata             = t_wdata_q;
  assign tgt_be                = t_be_q;
  assign tgt_wr                = t_wr_q;
  assign mst_rdata             = m_rdata_q;
  assign mst_done              = m_done_q;
  assign mst_abort             = m_abort_q;
  assign mst_busy              = m_busy_q;

endmodule

// *** sim/pci_bus_interface_checker.sv ***
// Concurrent checks on the host bus interface ports.
`timescale 1ns/10ps
module pci_bus_interface_checker (
  input wire logic        clk_sys, resetn, ad_drive_en, par_drive, par_drive_en, tgt_wr,
  input wire logic        cycle_frame_n, cycle_frame_n_drv, cycle_frame_en, initiator_ready_n,
  input wire logic        initiator_ready_n_drv, target_ready_n, device_select_n, mst_busy,
  input wire logic        device_select_n_drv, device_select_en, bus_request_en, mst_abort,
  input wire logic [31:0] ad_sample,         // Resolved address/data lines.
  input wire logic [3:0]  cmd_byte_enable_n  // Resolved command/byte-enable lines.
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // Address phase inside our window with a memory command.
  wire hit = ((ad_sample & pci_bus_pkg::TGT_MASK) == pci_bus_pkg::TGT_BASE) &&
             (cmd_byte_enable_n[3:1] == 3'h3);
  property p_rel;
    $rose(resetn) |-> !(ad_drive_en || cycle_frame_en || device_select_en || bus_request_en);
  endproperty
  a_rel: assert property (p_rel) else $error("bus driven at reset release");
  property p_par; par_drive_en |-> par_drive == ^{$past(ad_sample), $past(cmd_byte_enable_n)};
  endproperty
  a_par: assert property (p_par) else $error("parity not even");
  property p_pen; par_drive_en == $past(ad_drive_en); endproperty
  a_pen: assert property (p_pen) else $error("parity enable not one clock late");
  property p_claim;
    $fell(cycle_frame_n) && !cycle_frame_en && !mst_busy && hit |->
      ##2 device_select_en && !device_select_n_drv;
  endproperty
  a_claim: assert property (p_claim) else $error("claim not at medium speed");
  property p_wr; tgt_wr |-> $past(!initiator_ready_n && !target_ready_n); endproperty
  a_wr: assert property (p_wr) else $error("write without both ready");
  property p_mfr;
    $rose(cycle_frame_en) |-> !cycle_frame_n_drv && ad_drive_en
      ##1 cycle_frame_n_drv && !initiator_ready_n_drv;
  endproperty
  a_mfr: assert property (p_mfr) else $error("master framing wrong");
  property p_abt; mst_abort |-> !cycle_frame_en && !ad_drive_en; endproperty
  a_abt: assert property (p_abt) else $error("bus kept after abort");
  property p_dog; $rose(cycle_frame_en) ##1 device_select_n [*6] |-> ##[0:2] mst_abort;
  endproperty
  a_dog: assert property (p_dog) else $error("unclaimed access not aborted");
endmodule

// *** sim/bus_partner.sv ***
// Far-side model: arbiter and a memory target answering our master.
`timescale 1ns/10ps
module bus_partner (
  input  wire logic        clk_sys, resetn, frame_n, irdy_n, req_n, mute,
  input  wire logic [1:0]  lat,   // Clocks before the claim.
  input  wire logic [3:0]  cbe_n, // Command lines.
  input  wire logic [31:0] ad,    // Resolved address/data.
  input  wire logic [31:0] data,  // Word returned on reads.
  output logic             gnt_n, dv_n, tr_n, ad_oe,
  output logic      [31:0] ad_o,  // Read data driven.
  output logic      [31:0] got    // Word taken on writes.
);
  logic fr_q = 1'b1; // Frame at the previous edge.
  logic rd;          // Access is a read.
  int   i;           // Guard so a stuck master cannot hang us.
  always @(posedge clk_sys) fr_q <= frame_n;
  // Grant follows request, held off in reset.
  always @(posedge clk_sys) #1 gnt_n = req_n || !resetn;
  // Claim after lat clocks, then complete one word at both ready.
  initial begin
    {gnt_n, dv_n, tr_n, ad_oe} = 4'hE;
    forever begin
      @(posedge clk_sys);
      if (resetn && fr_q && !frame_n && !gnt_n && !mute) begin
        rd = !cbe_n[0];
        repeat (lat) @(posedge clk_sys);
        #1 {dv_n, tr_n, ad_oe, ad_o} = {2'b00, rd, data};
        i = 0;
        do begin @(posedge clk_sys); i++; end while (irdy_n && i < 9);
        got = ad;
        #1 {dv_n, tr_n, ad_oe} = 3'h6;
      end
    end
  end
endmodule

// *** sim/pci_bus_interface_bench.sv ***
// Self-checking bench of the host bus interface.
`timescale 1ns/10ps
module pci_bus_interface_bench;
  logic        clk_sys = 1'b0, resetn = 1'b0, mst_start = 1'b0, stop_n = 1'b1, mute = 1'b0;
  logic        b_ade = 1'b0, b_fr = 1'b1, b_ir = 1'b1; // Bench acting as a master.
  logic [31:0] mst_addr = '0, mst_wdata = '0, b_ad = '0, pd = '0, p_ad, got;
  logic [3:0]  mst_cmd = '0, mst_be_n = '0, b_cbe = '0, cmd_byte_enable_n_drv, tgt_be;
  logic [1:0]  lat = '0;
  logic [7:0]  cyc = '0; // Changing pattern for released lines.
  logic [15:0] rnd = 16'h0010;
  int          bad_count = 0, comparisons = 0;
  logic [31:0] ad_drive, tgt_addr, tgt_wdata, mst_rdata;
  logic par_drive, par_drive_en, ad_drive_en, cmd_byte_enable_en, cycle_frame_n_drv,
    cycle_frame_en, initiator_ready_n_drv, initiator_ready_en, target_ready_n_drv,
    target_ready_en, device_select_n_drv, device_select_en, bus_request_n, bus_request_en,
    tgt_wr, mst_done, mst_abort, mst_busy, bus_grant_n, p_dv, p_tr, p_oe;
  // Wire levels worked out from every party's enable.
  wire [31:0] ad_sample = ad_drive_en ? ad_drive : b_ade ? b_ad : p_oe ? p_ad : {4{cyc}};
  wire [31:0] tgt_rdata = tgt_addr ^ 32'hA5A5_5A5A;
  wire [3:0]  cmd_byte_enable_n = cmd_byte_enable_en ? cmd_byte_enable_n_drv :
                                  (!b_fr || !b_ir) ? b_cbe : cyc[3:0];
  wire cycle_frame_n = cycle_frame_en ? cycle_frame_n_drv : b_fr;
  wire initiator_ready_n = initiator_ready_en ? initiator_ready_n_drv : b_ir;
  wire target_ready_n = target_ready_en ? target_ready_n_drv : p_tr;
  wire device_select_n = device_select_en ? device_select_n_drv : p_dv;
  pci_bus_interface dut (.*);
  bus_partner peer (.clk_sys, .resetn, .frame_n(cycle_frame_n), .irdy_n(initiator_ready_n),
    .req_n(bus_request_en ? bus_request_n : 1'b1), .mute, .lat, .cbe_n(cmd_byte_enable_n),
    .ad(ad_sample), .data(pd), .gnt_n(bus_grant_n), .dv_n(p_dv), .tr_n(p_tr), .ad_oe(p_oe),
    .ad_o(p_ad), .got);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 8'h01;
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Reset of twelve clocks; no pin may be driven while it is held.
  task automatic rst();
    #1 resetn = 1'b0;
    repeat (12) @(posedge clk_sys);
    chk("enables in reset", 0, {ad_drive_en, bus_request_en, cycle_frame_en, p_oe});
    #1 resetn = 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  // Bench master access to the target; only memory commands in the window are claimed.
  task automatic tacc(input logic [3:0] c, input logic [31:0] a, d, input logic [3:0] be);
    logic hit;
    int i;
    hit = (a[31:12] == 20'h10000) && (c[3:1] == 3'h3);
    @(posedge clk_sys);
    #1 {b_fr, b_ade, b_ad, b_cbe} = {2'b01, a, c};
    @(posedge clk_sys);
    #1 {b_fr, b_ir, b_ade, b_ad, b_cbe} = {2'b10, c[0], d, ~be};
    i = 0;
    do begin @(posedge clk_sys); i++; end while (target_ready_n && i < 6);
    chk("claim", hit, !target_ready_n);
    if (hit && !c[0]) chk("target read", a ^ 32'hA5A5_5A5A, ad_sample);
    #1 {b_ir, b_ade} = 2'b10;
    chk("write strobe", hit && c[0], tgt_wr);
    if (hit && c[0]) chk("write data", d, tgt_wdata);
    if (hit && c[0]) chk("byte enables", be, tgt_be);
  endtask
  // Our master does one word; a mute far side must end in an abort.
  task automatic macc(input logic [3:0] c, input logic m);
    int i;
    pd = {rnd, ~rnd};
    mute = m;
    @(posedge clk_sys);
    #1 {mst_start, mst_cmd, mst_be_n, mst_wdata, mst_addr} = {1'b1, c, rnd[3:0], ~pd, pd};
    @(posedge clk_sys);
    #1 mst_start = 1'b0;
    i = 0;
    do begin @(posedge clk_sys); #1 i++; end while (!mst_done && !mst_abort && i < 20);
    chk("abort", m, mst_abort);
    if (!m && !c[0]) chk("master read", pd, mst_rdata);
    if (!m && c[0]) chk("master write", ~pd, got);
    repeat (3) @(posedge clk_sys);
  endtask
  initial begin
    rst();
    for (int c = 0; c < 16; c++) begin
      rnd = lfsr(rnd);
      tacc(c[3:0], 32'h1000_0FFC, {rnd, ~rnd}, rnd[3:0]);
    end
    tacc(4'h7, 32'h1000_1000, 32'h0000_0001, 4'hF);
    $display("target tests done");
    for (int l = 0; l < 3; l++) begin
      lat = l[1:0];
      rnd = lfsr(rnd);
      macc(4'h7, 1'b0);
      macc(4'h6, 1'b0);
    end
    macc(4'h7, 1'b1);
    $display("master tests done");
    rst();
    macc(4'h6, 1'b0);
    $display("reset test done");
    final_report();
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    bad_count++;
    final_report();
  end
endmodule
bind pci_bus_interface pci_bus_interface_checker watch (.*);
